// >>> sys_cfg_pkg.sv
package sys_cfg_pkg;

  // ******************************************************
  // bus and register map
  // ******************************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_GUARD = 8'h00;
  localparam logic [7:0] OFF_RAMSZ = 8'h04;
  localparam logic [7:0] OFF_FLASH = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;

  // ******************************************************
  // field layouts and reset values
  // ******************************************************
  localparam logic [15:0] GUARD_KEY = 16'h0096;
  localparam logic [15:0] GUARD_RST = 16'h0000;
  localparam logic [2:0] RAM_CODE_RST = 3'h2;
  localparam logic [4:0] RAMSZ_FIXED = 5'h04;
  localparam int RAMSZ_FIXED_POS = 3;
  localparam int RAMSZ_RSV_POS = 8;
  localparam logic [1:0] WAIT_RST = 2'h1;
  localparam int READY_POS = 7;
  localparam logic [2:0] RAM_CODE_MAX = 3'h2;

  // ******************************************************
  // ram sizes in bytes per code
  // ******************************************************
  localparam logic [11:0] RAM_512B = 12'h200;
  localparam logic [11:0] RAM_1KB = 12'h400;
  localparam logic [11:0] RAM_2KB = 12'h800;

  // ******************************************************
  // flash read sequencer
  // ******************************************************
  localparam int WAIT_W = 2;

endpackage : sys_cfg_pkg

// >>> flash_wait_seq.sv
`timescale 1ns/1ps

// counts a flash read access out over the programmed wait count plus one cycles
module flash_wait_seq (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [sys_cfg_pkg::WAIT_W-1:0] wait_count,
  input wire logic rd_start,
  output logic rd_busy,
  output logic rd_done
);
  import sys_cfg_pkg::*;

  typedef enum logic {IDLE, RUN} seq_e;

  seq_e state_r;
  seq_e state_nxt;
  logic [WAIT_W-1:0] cnt_r;
  logic [WAIT_W-1:0] cnt_nxt;
  wire last_cycle = (cnt_r == '0);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      IDLE: begin
        if (rd_start) begin
          state_nxt = RUN;
          cnt_nxt = wait_count;
        end
      end
      RUN: begin
        if (last_cycle) begin
          state_nxt = IDLE;
        end else begin
          cnt_nxt = cnt_r - 2'h1;
        end
      end
      default: begin
        state_nxt = IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= IDLE;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign rd_busy = (state_r == RUN);
  assign rd_done = (state_r == RUN) && last_cycle;

endmodule : flash_wait_seq

// >>> sys_misc_cfg.sv
// Function
// - The write guard is released only while the key field holds 0x0096.
// - While guarded, writes to guarded bits are dropped silently.
// - The 3-bit RAM size code selects 512B, 1KB or 2KB and resets to 0x2.
// - A read-only flag reads 1 when flash may be accessed, 0 otherwise.
// - Each flash read takes wait count plus one cycles; the count resets to 1.
// - A released guard stays released until software writes another key.
`timescale 1ns/1ps

module sys_misc_cfg (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [sys_cfg_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [sys_cfg_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [sys_cfg_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic flash_rd_req,
  input wire logic flash_prohibit,
  output logic flash_rd_ack,
  output logic flash_rd_busy,
  output logic [2:0] ram_size_code,
  output logic [11:0] ram_limit_bytes,
  output logic guard_open
);
  import sys_cfg_pkg::*;

  // ******************************************************
  // address phase capture
  // ******************************************************
  wire addr_valid = hsel && hready && htrans[1];
  logic wr_pend_r;
  logic [7:0] wr_addr_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_valid && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // ******************************************************
  // register file
  // ******************************************************
  logic [15:0] guard_key_field_r;
  logic [2:0] ram_size_code_r;
  logic ram_rsv_r;
  logic [1:0] flash_read_wait_count_r;

  wire guard_released = (guard_key_field_r == GUARD_KEY);
  wire wr_guard = wr_pend_r && (wr_addr_r == OFF_GUARD);
  wire wr_ramsz = wr_pend_r && (wr_addr_r == OFF_RAMSZ) && guard_released;
  wire wr_flash = wr_pend_r && (wr_addr_r == OFF_FLASH) && guard_released;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      guard_key_field_r <= GUARD_RST;
      ram_size_code_r <= RAM_CODE_RST;
      ram_rsv_r <= 1'b0;
      flash_read_wait_count_r <= WAIT_RST;
    end else begin
      if (wr_guard) begin
        guard_key_field_r <= hwdata[15:0];
      end
      if (wr_ramsz) begin
        ram_size_code_r <= hwdata[2:0];
        ram_rsv_r <= hwdata[RAMSZ_RSV_POS];
      end
      if (wr_flash) begin
        flash_read_wait_count_r <= hwdata[1:0];
      end
    end
  end

  // ******************************************************
  // ram limit decode
  // ******************************************************
  wire [11:0] ram_limit =
    (ram_size_code_r == 3'h0) ? RAM_512B :
    (ram_size_code_r == 3'h1) ? RAM_1KB : RAM_2KB;

  assign ram_size_code = ram_size_code_r;
  assign ram_limit_bytes = ram_limit;
  assign guard_open = guard_released;

  // ******************************************************
  // flash ready flag and read sequencer
  // ******************************************************
  logic flash_ready_flag_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_ready_flag_r <= 1'b1;
    end else begin
      flash_ready_flag_r <= !flash_prohibit;
    end
  end

  wire seq_busy;
  wire seq_done;
  wire rd_start = flash_rd_req && !seq_busy && flash_ready_flag_r;

  flash_wait_seq u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .wait_count(flash_read_wait_count_r),
    .rd_start(rd_start),
    .rd_busy(seq_busy),
    .rd_done(seq_done)
  );

  assign flash_rd_ack = seq_done;
  assign flash_rd_busy = seq_busy;

  // ******************************************************
  // read data
  // ******************************************************
  wire [15:0] guard_word = guard_key_field_r;
  wire [15:0] ramsz_word = {7'h00, ram_rsv_r, RAMSZ_FIXED, ram_size_code_r};
  wire [15:0] flash_word = {8'h00, flash_ready_flag_r, 5'h00,
                            flash_read_wait_count_r};
  wire [15:0] status_word = {13'h0000, seq_busy, guard_released,
                             ram_size_code_r > RAM_CODE_MAX};
  wire [7:0] ra = haddr[7:0];
  wire [15:0] rd_sel =
    (ra == OFF_GUARD) ? guard_word :
    (ra == OFF_RAMSZ) ? ramsz_word :
    (ra == OFF_FLASH) ? flash_word :
    (ra == OFF_STATUS) ? status_word : 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_valid && !hwrite) begin
      hrdata <= {16'h0000, rd_sel};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : sys_misc_cfg

// >>> sys_misc_cfg_properties.sv
`timescale 1ns/1ps
module sys_misc_cfg_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic flash_rd_req,
  input wire logic flash_prohibit,
  input wire logic flash_rd_ack,
  input wire logic flash_rd_busy,
  input wire logic [2:0] ram_size_code,
  input wire logic [11:0] ram_limit_bytes,
  input wire logic guard_open
);
  // ****
  // checks
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_end; flash_rd_busy ##1 !flash_rd_busy; endsequence
  property p_lim; ram_limit_bytes == (ram_size_code == 3'h0 ? 12'h200 :
    ram_size_code == 3'h1 ? 12'h400 : 12'h800); endproperty
  a_lim: assert property (p_lim) else $error("ram limit");
  property p_ram; $changed(ram_size_code) |-> $past(guard_open); endproperty
  a_ram: assert property (p_ram) else $error("guarded write");
  property p_key; $changed(guard_open) |->
    guard_open == ($past(hwdata[15:0]) == 16'h0096); endproperty
  a_key: assert property (p_key) else $error("guard state");
  property p_start; $rose(flash_rd_busy) |->
    $past(flash_rd_req) && !$past(flash_prohibit, 2); endproperty
  a_start: assert property (p_start) else $error("read start");
  property p_win; $rose(flash_rd_busy) |-> ##[0:3] flash_rd_ack; endproperty
  a_win: assert property (p_win) else $error("read length");
  property p_ack; flash_rd_ack |-> s_end; endproperty
  a_ack: assert property (p_ack) else $error("read end");
  property p_hold; flash_rd_busy && !flash_rd_ack |=> flash_rd_busy;
  endproperty
  a_hold: assert property (p_hold) else $error("busy drop");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus response");
endmodule : sys_misc_cfg_properties
bind sys_misc_cfg sys_misc_cfg_properties u_props (.*);

// >>> sys_misc_cfg_tb_top.sv
`timescale 1ns/1ps
module sys_misc_cfg_tb_top;
  import sys_cfg_pkg::*;
  logic hclk = 0, hresetn = 0, hwrite = 0, req = 0, prohib = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] rcode;
  logic [11:0] rlim;
  logic hreadyout, hresp, ack, busy, gopen;
  int mismatches = 0, tests_run = 0, key, code, n;
  always #2 hclk = ~hclk;
  sys_misc_cfg DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_rd_req(req),
    .flash_prohibit(prohib), .flash_rd_ack(ack), .flash_rd_busy(busy),
    .ram_size_code(rcode), .ram_limit_bytes(rlim), .guard_open(gopen));
  // ****
  // tasks
  // ****
  task automatic chk(input string s, input logic [31:0] e, g);
    tests_run++;
    if (e !== g) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input int d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input int e);
    bus(a, 0, 0);
    chk("rdata", e, q);
  endtask : rd
  task automatic fr(input int w);
    req <= 1;
    @(posedge hclk);
    req <= 0;
    n = 0;
    do begin @(negedge hclk); n++; end while (ack !== 1'b1 && n < 9);
    chk("ack delay", w + 1, n);
    @(posedge hclk);
  endtask : fr
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    #5000;
    mismatches++;
    close_out;
  end
  initial begin
    n = $urandom(32'hE93775BE);
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    rd(OFF_GUARD, 0);
    rd(OFF_RAMSZ, 32'h22);
    rd(OFF_FLASH, 32'h81);
    bus(OFF_RAMSZ, 1, $urandom % 2);
    rd(OFF_RAMSZ, 32'h22);
    $display("test reset_guard done");
    bus(OFF_GUARD, 1, GUARD_KEY);
    rd(OFF_GUARD, GUARD_KEY);
    chk("guard", 1, gopen);
    rd(OFF_STATUS, 32'h2);
    for (int i = 0; i < 4; i++) begin
      code = i % 3;
      bus(OFF_RAMSZ, 1, code);
      bus(OFF_FLASH, 1, i);
      rd(OFF_RAMSZ, 32'h20 | code);
      chk("size code", code, rcode);
      chk("limit", 512 << code, rlim);
      rd(OFF_FLASH, 32'h80 | i);
      fr(i);
    end
    key = ($urandom & 16'h7F00) | 1;
    bus(OFF_GUARD, 1, key);
    bus(OFF_FLASH, 1, 0);
    rd(OFF_FLASH, 32'h83);
    chk("guard", 0, gopen);
    $display("test unlock done");
    prohib <= 1;
    @(posedge hclk);
    rd(OFF_FLASH, 32'h03);
    req <= 1;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk("busy", 0, busy);
    @(posedge hclk);
    req <= 0;
    prohib <= 0;
    rd(8'h10, 0);
    $display("test prohibit done");
    close_out;
  end
endmodule : sys_misc_cfg_tb_top
